//--- hdl/scc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - writes to the poll request bit of operating_control are dropped.
// - default_restore write returns mode, setpoint, overrange, alarm, alert and extended registers to power-on values; sensed flags keep theirs.
// - setpoint_clear zeroes both setpoints, even while charge_hold is set.
// - status charge_hold_flag mirrors the stored charge_hold bit, including its self-clearing and restore.
// - poll, voltage-unregulated and current-unregulated status bits always read zero.
// - status always reports a level 2 charger as a constant bit.
// - current overrange sets only above the limit; limit plus one sets it.
// - voltage overrange sets when setpoint reaches or exceeds the maximum voltage.
// - sense_open_flag sets above 95 kilohms, meaning no battery.
// - sense_cold_flag sets above 28.5 kilohms and whenever open is set.
// - sense_hot_flag sets below 3150 ohms and whenever underrange is set.
// - sense_underrange_flag sets only below 575 ohms.
// - alarm hold sets on inhibiting alarm; clears on both setpoints, adapter loss, removal.
// - alert pull-down asserts whenever alarm_hold_flag becomes set.
// - supply_low_flag on poor supply or external enable low; disables charging.
// - supply_low leaves stored setpoints and charging modes untouched.
// - pack_detect_flag clears on the same sample that shows an open thermistor.
// - pack_detect_flag sets only after two successive non-open samples.
// - without adapter, pack detection may lag up to half a second.
// - pack detect clearing zeroes both setpoints; no charging while it is clear.
// - alert pull-down asserts on every change of pack_detect_flag.
// - adapter_detect_flag follows the adapter comparator; not a supply guarantee.
// - charge_hold clears itself on power return or battery reinsertion.
// - any of alarm bits 15..12 inhibits charging and sets alarm hold.
// - alert response read during alert returns own address byte.
// - alert releases after a status read or an alert response transaction.
module scc_regs #(
	parameter logic [11:0] VERSION_ID = 12'h0A5 // arbitrary value
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// command port from the bus interface
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic        ara_rd,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic [15:0]      rd_data,
	output logic             rd_valid,
	output logic             rd_err,
	// limit straps
	input  wire logic [1:0]  ilim_sel,
	input  wire logic [2:0]  vlim_sel,
	// thermistor sample
	input  wire logic        therm_stb,
	input  wire logic [19:0] therm_ohms,
	// supply sensing
	input  wire logic        adapter_sense_input,
	input  wire logic        input_supply_pin,
	// charge enable open-drain pin
	input  wire logic        charge_enable_pin_in,
	output logic             charge_enable_pin_out,
	output logic             charge_enable_pin_oe_n,
	// alert open-drain pin
	output logic             alert_out,
	output logic             alert_oe_n,
	// charger controls
	output logic [15:0]      curr_dac,
	output logic [15:0]      volt_dac,
	output logic             charge_permit,
	output logic             pulsed_low_current_disable
);

	// sensed flags
	logic sense_open;
	logic sense_cold;
	logic sense_hot;
	logic sense_under;
	logic pack_detect;

	scc_sense u_sense (
		.mclk                  (mclk),
		.resetn                (resetn),
		.clk_en                (clk_en),
		.sample_stb            (therm_stb),
		.therm_ohms            (therm_ohms),
		.sense_open_flag       (sense_open),
		.sense_cold_flag       (sense_cold),
		.sense_hot_flag        (sense_hot),
		.sense_underrange_flag (sense_under),
		.pack_detect_flag      (pack_detect)
	);

	// state
	logic        charge_hold_r;
	logic        charge_hold_nxt;
	logic [15:0] curr_set_r;
	logic [15:0] curr_set_nxt;
	logic [15:0] volt_set_r;
	logic [15:0] volt_set_nxt;
	logic        curr_or_r;
	logic        curr_or_nxt;
	logic        volt_or_r;
	logic        volt_or_nxt;
	logic        alarm_hold_r;
	logic        alarm_hold_nxt;
	logic        cur_seen_r;
	logic        cur_seen_nxt;
	logic        volt_seen_r;
	logic        volt_seen_nxt;
	logic        alert_r;
	logic        alert_nxt;
	logic        pulsed_low_r;
	logic        pulsed_low_nxt;
	logic        pack_prev_r;
	logic        adapter_prev_r;

	// decode
	logic wr_mode;
	logic wr_curr;
	logic wr_volt;
	logic wr_alarm;
	logic wr_ext;
	logic restore;
	logic zero_set;
	logic rd_spec;
	logic rd_status;
	logic rd_ext;
	logic rd_hit;
	logic ara_hit;

	assign wr_mode  = cmd_wr && (cmd_code == scc_pkg::CMD_OPERATING_CONTROL);
	assign wr_curr  = cmd_wr && (cmd_code == scc_pkg::CMD_CURRENT_SETPOINT);
	assign wr_volt  = cmd_wr && (cmd_code == scc_pkg::CMD_VOLTAGE_SETPOINT);
	assign wr_alarm = cmd_wr && (cmd_code == scc_pkg::CMD_BATTERY_ALARM_INPUT);
	assign wr_ext   = cmd_wr && (cmd_code == scc_pkg::CMD_EXTENDED_MODE_VERSION);
	assign restore  = wr_mode && cmd_wdata[scc_pkg::OC_DEFAULT_RESTORE];
	assign zero_set = wr_mode && cmd_wdata[scc_pkg::OC_SETPOINT_CLEAR];

	assign rd_spec   = cmd_rd && (cmd_code == scc_pkg::CMD_SPEC_REVISION_INFO);
	assign rd_status = cmd_rd && (cmd_code == scc_pkg::CMD_STATUS_FLAGS);
	assign rd_ext    = cmd_rd && (cmd_code == scc_pkg::CMD_EXTENDED_MODE_VERSION);
	assign rd_hit    = rd_spec || rd_status || rd_ext;
	assign ara_hit   = ara_rd && alert_r;

	// limits
	logic [15:0] curr_max;
	logic [15:0] volt_max;

	assign curr_max = (ilim_sel == 2'd0) ? scc_pkg::ILIM_0 :
		(ilim_sel == 2'd1) ? scc_pkg::ILIM_1 :
		(ilim_sel == 2'd2) ? scc_pkg::ILIM_2 : scc_pkg::ILIM_3;
	assign volt_max = (vlim_sel == 3'd0) ? scc_pkg::VLIM_0 :
		(vlim_sel == 3'd1) ? scc_pkg::VLIM_1 :
		(vlim_sel == 3'd2) ? scc_pkg::VLIM_2 :
		(vlim_sel == 3'd3) ? scc_pkg::VLIM_3 : scc_pkg::VLIM_4;

	// setpoint conditioning: out of range values are clipped to the limit
	logic        curr_over;
	logic        volt_over;
	logic [15:0] curr_clip;
	logic [15:0] volt_clip;

	assign curr_over = cmd_wdata > curr_max;
	assign volt_over = cmd_wdata >= volt_max;
	assign curr_clip = curr_over ? curr_max : cmd_wdata;
	assign volt_clip = volt_over ? volt_max :
		(cmd_wdata <= scc_pkg::VOLT_ZERO_BAND) ? 16'h0000 : cmd_wdata;

	// supply and presence events
	logic ext_enable_low;
	logic supply_low;
	logic adapter_detect;
	logic adapter_rise;
	logic adapter_fall;
	logic pack_rise;
	logic pack_fall;
	logic alarm_inhibit;

	// the own pull-down is excluded so that disabling does not latch itself
	assign ext_enable_low = !charge_enable_pin_in && charge_enable_pin_oe_n;
	assign supply_low     = !input_supply_pin || ext_enable_low;
	assign adapter_detect = adapter_sense_input;
	assign adapter_rise   = adapter_detect && !adapter_prev_r;
	assign adapter_fall   = !adapter_detect && adapter_prev_r;
	assign pack_rise      = pack_detect && !pack_prev_r;
	assign pack_fall      = !pack_detect && pack_prev_r;
	assign alarm_inhibit  = wr_alarm && |(cmd_wdata & scc_pkg::ALARM_INHIBIT_MASK);

	// mode bits; poll request is never stored
	assign charge_hold_nxt = restore ? scc_pkg::RST_CHARGE_HOLD :
		(adapter_rise || pack_rise) ? 1'b0 :
		wr_mode ? cmd_wdata[scc_pkg::OC_CHARGE_HOLD] : charge_hold_r;

	// setpoints: supply_low has no say here
	assign curr_set_nxt = (restore || zero_set || pack_fall) ? scc_pkg::RST_SETPOINT :
		wr_curr ? curr_clip : curr_set_r;
	assign volt_set_nxt = (restore || zero_set || pack_fall) ? scc_pkg::RST_SETPOINT :
		wr_volt ? volt_clip : volt_set_r;
	assign curr_or_nxt = restore ? 1'b0 : wr_curr ? curr_over : curr_or_r;
	assign volt_or_nxt = restore ? 1'b0 : wr_volt ? volt_over : volt_or_r;

	// alarm hold: a new inhibiting alarm wins over any clear in the same cycle
	logic alarm_clear;

	assign cur_seen_nxt  = (alarm_inhibit || alarm_clear || restore) ? 1'b0 :
		(wr_curr ? 1'b1 : cur_seen_r);
	assign volt_seen_nxt = (alarm_inhibit || alarm_clear || restore) ? 1'b0 :
		(wr_volt ? 1'b1 : volt_seen_r);
	assign alarm_clear = ((cur_seen_r || wr_curr) && (volt_seen_r || wr_volt)) ||
		adapter_fall || pack_fall;
	assign alarm_hold_nxt = alarm_inhibit ? 1'b1 :
		(alarm_clear || restore) ? 1'b0 : alarm_hold_r;

	// alert: any trigger beats a release in the same cycle and holds until released
	logic alert_set;
	logic alert_release;

	assign alert_set = (alarm_inhibit && !alarm_hold_r) ||
		pack_rise || pack_fall ||
		adapter_rise || adapter_fall || restore;
	assign alert_release = rd_status || ara_hit;
	assign alert_nxt = alert_set ? 1'b1 : alert_release ? 1'b0 : alert_r;

	assign pulsed_low_nxt = restore ? scc_pkg::RST_PULSED_LOW :
		wr_ext ? cmd_wdata[scc_pkg::EX_PULSED_LOW_DISABLE] : pulsed_low_r;

	// charging is only permitted with a pack, a supply and no hold of any kind
	logic permit_nxt;

	assign permit_nxt = pack_detect && !supply_low && !charge_hold_r &&
		!alarm_hold_r && !sense_hot && (curr_set_r != 16'h0000) &&
		(volt_set_r != 16'h0000);

	// read words
	logic [15:0] status_word;
	logic [15:0] ext_word;
	logic [15:0] rd_word;

	always_comb begin
		status_word = 16'h0000;
		status_word[scc_pkg::ST_CHARGE_HOLD]    = charge_hold_r;
		status_word[scc_pkg::ST_LEVEL]          = scc_pkg::LEVEL2_BIT;
		status_word[scc_pkg::ST_VOLT_OVERRANGE] = volt_or_r;
		status_word[scc_pkg::ST_CURR_OVERRANGE] = curr_or_r;
		status_word[scc_pkg::ST_SENSE_OPEN]     = sense_open;
		status_word[scc_pkg::ST_SENSE_COLD]     = sense_cold;
		status_word[scc_pkg::ST_SENSE_HOT]      = sense_hot;
		status_word[scc_pkg::ST_SENSE_UNDER]    = sense_under;
		status_word[scc_pkg::ST_ALARM_HOLD]     = alarm_hold_r;
		status_word[scc_pkg::ST_SUPPLY_LOW]     = supply_low;
		status_word[scc_pkg::ST_PACK_DETECT]    = pack_detect;
		status_word[scc_pkg::ST_ADAPTER_DETECT] = adapter_detect;
	end

	always_comb begin
		ext_word = {4'h0, VERSION_ID};
		ext_word[scc_pkg::EX_PULSED_LOW_DISABLE] = pulsed_low_r;
	end

	assign rd_word = ara_hit ? {8'h00, scc_pkg::ARA_ADDR_BYTE} :
		rd_status ? status_word :
		rd_ext ? ext_word :
		rd_spec ? scc_pkg::SPEC_INFO_VALUE : 16'h0000;

	// control registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			charge_hold_r <= scc_pkg::RST_CHARGE_HOLD;
			curr_set_r    <= scc_pkg::RST_SETPOINT;
			volt_set_r    <= scc_pkg::RST_SETPOINT;
			curr_or_r     <= 1'b0;
			volt_or_r     <= 1'b0;
			pulsed_low_r  <= scc_pkg::RST_PULSED_LOW;
		end else if (clk_en) begin
			charge_hold_r <= charge_hold_nxt;
			curr_set_r    <= curr_set_nxt;
			volt_set_r    <= volt_set_nxt;
			curr_or_r     <= curr_or_nxt;
			volt_or_r     <= volt_or_nxt;
			pulsed_low_r  <= pulsed_low_nxt;
		end
	end

	// event registers; power-on raises the alert
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			alarm_hold_r   <= 1'b0;
			cur_seen_r     <= 1'b0;
			volt_seen_r    <= 1'b0;
			alert_r        <= scc_pkg::RST_ALERT;
			pack_prev_r    <= 1'b0;
			adapter_prev_r <= 1'b0;
		end else if (clk_en) begin
			alarm_hold_r   <= alarm_hold_nxt;
			cur_seen_r     <= cur_seen_nxt;
			volt_seen_r    <= volt_seen_nxt;
			alert_r        <= alert_nxt;
			pack_prev_r    <= pack_detect;
			adapter_prev_r <= adapter_detect;
		end
	end

	// read answer registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
			rd_err   <= 1'b0;
		end else if (clk_en) begin
			rd_data  <= rd_word;
			rd_valid <= rd_hit || ara_hit;
			rd_err   <= (cmd_rd && !rd_hit) || (ara_rd && !alert_r);
		end
	end

	// pin drivers; charge enable pulled low whenever charging is not permitted
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			alert_out              <= 1'b0;
			alert_oe_n             <= 1'b0;
			charge_enable_pin_out  <= 1'b0;
			charge_enable_pin_oe_n <= 1'b0;
			charge_permit          <= 1'b0;
			curr_dac               <= 16'h0000;
			volt_dac               <= 16'h0000;
			pulsed_low_current_disable <= 1'b0;
		end else if (clk_en) begin
			alert_out              <= 1'b0;
			alert_oe_n             <= !alert_nxt;
			charge_enable_pin_out  <= 1'b0;
			charge_enable_pin_oe_n <= permit_nxt;
			charge_permit          <= permit_nxt;
			curr_dac               <= curr_set_nxt;
			volt_dac               <= volt_set_nxt;
			pulsed_low_current_disable <= pulsed_low_nxt;
		end
	end

	// presence timing without adapter is set by the sample rate upstream

endmodule : scc_regs

`default_nettype wire

//--- shared/scc_pkg.sv
package scc_pkg;

	// command codes of the word functions
	localparam logic [7:0] CMD_SPEC_REVISION_INFO    = 8'h11;
	localparam logic [7:0] CMD_OPERATING_CONTROL     = 8'h12;
	localparam logic [7:0] CMD_STATUS_FLAGS          = 8'h13;
	localparam logic [7:0] CMD_CURRENT_SETPOINT      = 8'h14;
	localparam logic [7:0] CMD_VOLTAGE_SETPOINT      = 8'h15;
	localparam logic [7:0] CMD_BATTERY_ALARM_INPUT   = 8'h16;
	localparam logic [7:0] CMD_EXTENDED_MODE_VERSION = 8'h3C;

	// own address byte returned on an alert response read
	localparam logic [7:0] ARA_ADDR_BYTE = 8'h12;

	// operating_control bit positions
	localparam int OC_CHARGE_HOLD     = 0;
	localparam int OC_POLL_REQUEST    = 1;
	localparam int OC_DEFAULT_RESTORE = 2;
	localparam int OC_SETPOINT_CLEAR  = 3;

	// status_flags bit positions
	localparam int ST_CHARGE_HOLD     = 0;
	localparam int ST_POLL            = 1;
	localparam int ST_VOLT_UNREG      = 2;
	localparam int ST_CURR_UNREG      = 3;
	localparam int ST_LEVEL           = 4;
	localparam int ST_VOLT_OVERRANGE  = 6;
	localparam int ST_CURR_OVERRANGE  = 7;
	localparam int ST_SENSE_OPEN      = 8;
	localparam int ST_SENSE_COLD      = 9;
	localparam int ST_SENSE_HOT       = 10;
	localparam int ST_SENSE_UNDER     = 11;
	localparam int ST_ALARM_HOLD      = 12;
	localparam int ST_SUPPLY_LOW      = 13;
	localparam int ST_PACK_DETECT     = 14;
	localparam int ST_ADAPTER_DETECT  = 15;

	// extended_mode_version layout
	localparam int EX_PULSED_LOW_DISABLE = 12;

	// fixed read values
	localparam logic [15:0] SPEC_INFO_VALUE = 16'h0002;
	localparam logic        LEVEL2_BIT      = 1'b1;

	// battery alarm bits that inhibit charging (15..12)
	localparam logic [15:0] ALARM_INHIBIT_MASK = 16'hF000;

	// voltage codes up to this value count as zero
	localparam logic [15:0] VOLT_ZERO_BAND = 16'h049F;

	// current limits per limit select
	localparam logic [15:0] ILIM_0 = 16'h03FF;
	localparam logic [15:0] ILIM_1 = 16'h07FF;
	localparam logic [15:0] ILIM_2 = 16'h0BFF;
	localparam logic [15:0] ILIM_3 = 16'h0FFF;

	// voltage limits per limit select
	localparam logic [15:0] VLIM_0 = 16'h225F;
	localparam logic [15:0] VLIM_1 = 16'h332F;
	localparam logic [15:0] VLIM_2 = 16'h43FF;
	localparam logic [15:0] VLIM_3 = 16'h54CF;
	localparam logic [15:0] VLIM_4 = 16'h6D5F;

	// thermistor thresholds in ohms
	localparam logic [19:0] OHM_OPEN  = 20'd95000;
	localparam logic [19:0] OHM_COLD  = 20'd28500;
	localparam logic [19:0] OHM_HOT   = 20'd3150;
	localparam logic [19:0] OHM_UNDER = 20'd575;

	// reset values
	localparam logic        RST_CHARGE_HOLD = 1'b0;
	localparam logic        RST_ALERT       = 1'b1;
	localparam logic [15:0] RST_SETPOINT    = 16'h0000;
	localparam logic        RST_PULSED_LOW  = 1'b0;

	// clean thermistor samples needed before a pack counts as present
	localparam logic [1:0] PACK_GOOD_SAMPLES = 2'd2;

endpackage : scc_pkg

//--- hdl/scc_sense.sv
`timescale 1ns/1ps
`default_nettype none

// thermistor decoder: classifies each resistance sample and filters pack presence
module scc_sense (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// decoded thermistor sample
	input  wire logic        sample_stb,
	input  wire logic [19:0] therm_ohms,
	// classification
	output logic             sense_open_flag,
	output logic             sense_cold_flag,
	output logic             sense_hot_flag,
	output logic             sense_underrange_flag,
	output logic             pack_detect_flag
);

	logic       is_open;
	logic       is_cold;
	logic       is_hot;
	logic       is_under;
	logic [1:0] good_cnt_r;
	logic [1:0] good_cnt_nxt;
	logic       pack_nxt;

	assign is_open  = therm_ohms > scc_pkg::OHM_OPEN;
	assign is_cold  = (therm_ohms > scc_pkg::OHM_COLD) | is_open;
	assign is_under = therm_ohms < scc_pkg::OHM_UNDER;
	assign is_hot   = (therm_ohms < scc_pkg::OHM_HOT) | is_under;

	// open clears presence on the same sample; two clean samples in a row set it
	assign good_cnt_nxt = is_open ? 2'd0 :
		(good_cnt_r == scc_pkg::PACK_GOOD_SAMPLES) ? good_cnt_r : good_cnt_r + 2'd1;
	assign pack_nxt = (good_cnt_nxt == scc_pkg::PACK_GOOD_SAMPLES);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sense_open_flag       <= 1'b1;
			sense_cold_flag       <= 1'b1;
			sense_hot_flag        <= 1'b0;
			sense_underrange_flag <= 1'b0;
			pack_detect_flag      <= 1'b0;
			good_cnt_r            <= 2'd0;
		end else if (clk_en && sample_stb) begin
			sense_open_flag       <= is_open;
			sense_cold_flag       <= is_cold;
			sense_hot_flag        <= is_hot;
			sense_underrange_flag <= is_under;
			good_cnt_r            <= good_cnt_nxt;
			pack_detect_flag      <= pack_nxt;
		end
	end

endmodule : scc_sense

`default_nettype wire

//--- dv/scc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checks of the command and status bank
module scc_regs_monitor #(
	parameter logic [11:0] VERSION_ID = 12'h0A5 // arbitrary value
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        clk_en,
	// command port
	input wire logic        cmd_wr,
	input wire logic        cmd_rd,
	input wire logic        ara_rd,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] rd_data,
	input wire logic        rd_valid,
	input wire logic        rd_err,
	// straps, supply and controls
	input wire logic [1:0]  ilim_sel,
	input wire logic        input_supply_pin,
	input wire logic        alert_oe_n,
	input wire logic [15:0] curr_dac,
	input wire logic [15:0] volt_dac,
	input wire logic        charge_permit,
	input wire logic        pulsed_low_current_disable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	wire logic rd_go = clk_en && cmd_rd;
	wire logic wr_go = clk_en && cmd_wr;
	wire logic st_rd = rd_go && cmd_code == scc_pkg::CMD_STATUS_FLAGS;
	wire logic wo_rd = rd_go && cmd_code inside {8'h12, 8'h14, 8'h15, 8'h16};
	wire logic ext_rd = rd_go && cmd_code == scc_pkg::CMD_EXTENDED_MODE_VERSION;
	wire logic cur_wr = wr_go && cmd_code == scc_pkg::CMD_CURRENT_SETPOINT;
	wire logic alm_wr = wr_go && cmd_code == scc_pkg::CMD_BATTERY_ALARM_INPUT;
	wire logic [15:0] ext_word = {3'h0, pulsed_low_current_disable, VERSION_ID};

	sequence s_mode_bit(int b);
		wr_go && cmd_code == scc_pkg::CMD_OPERATING_CONTROL && cmd_wdata[b];
	endsequence
	sequence s_answer(logic [15:0] v);
		rd_valid && !rd_err && rd_data == v;
	endsequence

	AST_STATUS_FIXED: assert property (st_rd |=> rd_valid && rd_data[5:1] == 5'h08)
		else $error("status fixed bits wrong");
	AST_EXT_READ: assert property (ext_rd |=> s_answer(ext_word))
		else $error("extended word wrong");
	AST_WO_REFUSED: assert property (wo_rd |=> rd_err && !rd_valid)
		else $error("write-only read not refused");
	AST_ARA_ADDR: assert property (clk_en && ara_rd && !alert_oe_n |=> s_answer(16'h0012))
		else $error("alert response address wrong");
	AST_ALERT_KEEP: assert property (!alert_oe_n && !(rd_go || ara_rd) |=> !alert_oe_n)
		else $error("alert released without cause");
	AST_SETPOINT_CLEAR: assert property (s_mode_bit(3) |=> curr_dac == 0 && volt_dac == 0)
		else $error("setpoints not cleared");
	AST_RESTORE: assert property (s_mode_bit(2) |=> !alert_oe_n && !pulsed_low_current_disable)
		else $error("restore left state");
	AST_HOLD_BLOCKS: assert property (s_mode_bit(0) |-> ##[1:2] !charge_permit)
		else $error("hold did not stop charging");
	AST_CURR_CLIP: assert property (cur_wr && ilim_sel == 2'd0 && cmd_wdata > 16'h03FF |=>
		curr_dac == 16'h03FF)
		else $error("current not clipped");
	AST_SUPPLY_LOW: assert property ((!input_supply_pin)[*3] |-> !charge_permit)
		else $error("charging on poor supply");
	AST_NO_SETPOINT: assert property ((curr_dac == 16'h0000)[*2] |-> !charge_permit)
		else $error("charging with zero setpoint");
	AST_ALARM_BLOCKS: assert property (alm_wr && cmd_wdata[15:12] != 4'h0 |-> ##[1:2] !charge_permit)
		else $error("alarm did not stop charging");
endmodule : scc_regs_monitor

bind scc_regs scc_regs_monitor #(.VERSION_ID(VERSION_ID)) scc_regs_monitor_inst (.*);

`default_nettype wire

//--- dv/scc_host.sv
`timescale 1ns/1ps
`default_nettype none

// bus master in the place of the host or the battery
module scc_host (
	// clock
	input  wire logic        mclk,
	// command port
	output wire logic        cmd_wr,
	output wire logic        cmd_rd,
	output wire logic        ara_rd,
	output wire logic [7:0]  cmd_code,
	output wire logic [15:0] cmd_wdata,
	// answer
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_valid,
	input  wire logic        rd_err
);
	logic        act  = 1'b0;
	logic [1:0]  kind = 2'd0;
	logic [7:0]  code = 8'h00;
	logic [15:0] data = 16'h0000;
	logic [15:0] pat  = 16'h5A5A;

	// idle lines carry noise so a stale value is never taken for data
	always @(posedge mclk) pat <= ~pat + 16'h0001;
	assign cmd_wr    = act && kind == 2'd0;
	assign cmd_rd    = act && kind == 2'd1;
	assign ara_rd    = act && kind == 2'd2;
	assign cmd_code  = act ? code : pat[7:0];
	assign cmd_wdata = act ? data : pat;

	task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic [1:0] ans);
		int n;
		@(posedge mclk);
		kind <= k;
		code <= c;
		data <= d;
		act  <= 1'b1;
		@(posedge mclk);
		act <= 1'b0;
		q   = 16'h0000;
		ans = 2'b00;
		// answer stands for one cycle after the taking edge; look at it mid-cycle
		for (n = 0; n < 3 && k != 2'd0 && ans == 2'b00; n++) begin
			@(negedge mclk);
			q   = rd_data;
			ans = {rd_err, rd_valid};
		end
	endtask : xfer
endmodule : scc_host

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam logic [11:0] VER = 12'h0A5; // arbitrary value
	localparam logic [7:0]  CUR = scc_pkg::CMD_CURRENT_SETPOINT;
	localparam logic [7:0]  VOL = scc_pkg::CMD_VOLTAGE_SETPOINT;
	localparam logic [7:0]  MOD = scc_pkg::CMD_OPERATING_CONTROL;
	localparam logic [7:0]  STA = scc_pkg::CMD_STATUS_FLAGS;
	localparam logic [7:0]  EXT = scc_pkg::CMD_EXTENDED_MODE_VERSION;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        clk_en = 1'b1;
	logic [1:0]  ilim_sel = 2'd0;
	logic [2:0]  vlim_sel = 3'd0;
	logic        therm_stb = 1'b0;
	logic [19:0] therm_ohms = 20'd0;
	logic        adapter_sense_input = 1'b1;
	logic        input_supply_pin = 1'b1;
	wire logic   cmd_wr, cmd_rd, ara_rd, rd_valid, rd_err, alert_oe_n, charge_permit, pld;
	wire logic   chg_in, chg_out, chg_oe_n;
	wire logic [7:0]  cmd_code;
	wire logic [15:0] cmd_wdata, rd_data, curr_dac, volt_dac;
	logic [15:0] q;
	logic [1:0]  ans;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          i;
	logic [19:0] oh [8] = '{95000, 95001, 28500, 28501, 3150, 3149, 575, 574};
	logic [15:0] sb [8] = '{16'h0200, 16'h0300, 16'h0000, 16'h0200, 16'h0000, 16'h0400,
		16'h0400, 16'h0C00};
	logic [15:0] il [4] = '{scc_pkg::ILIM_0, scc_pkg::ILIM_1, scc_pkg::ILIM_2, scc_pkg::ILIM_3};
	logic [15:0] vl [5] = '{scc_pkg::VLIM_0, scc_pkg::VLIM_1, scc_pkg::VLIM_2, scc_pkg::VLIM_3,
		scc_pkg::VLIM_4};
	logic [7:0]  bad [3] = '{CUR, 8'h20, MOD};

	// charge enable has a pull-up and nobody else pulls it here
	assign chg_in = chg_oe_n ? 1'b1 : chg_out;

	scc_regs #(.VERSION_ID(VER)) scc_regs_inst (
		.*, .charge_enable_pin_in(chg_in), .charge_enable_pin_out(chg_out),
		.charge_enable_pin_oe_n(chg_oe_n), .alert_out(), .pulsed_low_current_disable(pld)
	);
	scc_host scc_host_inst (.*);

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic chb(input string nm, input logic seen, input logic exp);
		chk(nm, {15'h0, seen}, {15'h0, exp});
	endtask : chb

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		scc_host_inst.xfer(2'd0, c, d, q, ans);
	endtask : wr

	// a missing answer ends the run at once
	task automatic rd(input logic [1:0] k, input logic [7:0] c);
		scc_host_inst.xfer(k, c, 16'h0000, q, ans);
		if (ans === 2'b00) begin
			error_cnt++;
			give_verdict();
		end
	endtask : rd

	task automatic therm(input logic [19:0] o);
		@(posedge mclk);
		therm_stb  <= 1'b1;
		therm_ohms <= o;
		@(posedge mclk);
		therm_stb  <= 1'b0;
	endtask : therm

	initial begin
		cyc(4);
		resetn <= 1'b1;
		rd(2'd1, scc_pkg::CMD_SPEC_REVISION_INFO);
		chk("spec", q, scc_pkg::SPEC_INFO_VALUE);
		rd(2'd1, EXT);
		chk("ext", q, {4'h0, VER});
		foreach (bad[i]) begin
			rd(2'd1, bad[i]);
			chk("refuse", {14'h0, ans}, 16'h0002);
		end
		rd(2'd2, 8'h00);
		chk("ara", q, 16'h0012);
		chb("alert", alert_oe_n, 1'b1);
		rd(2'd2, 8'h00);
		chk("ara nack", {14'h0, ans}, 16'h0002);
		rd(2'd1, STA);
		chk("status", q, 16'h8310);
		therm(20'd10000);
		rd(2'd1, STA);
		chk("pack", q & 16'h4000, 16'h0000);
		therm(20'd10000);
		cyc(2);
		chb("alert", alert_oe_n, 1'b0);
		rd(2'd1, STA);
		chk("status", q, 16'hC010);
		chb("alert", alert_oe_n, 1'b1);
		wr(CUR, 16'h0400);
		rd(2'd1, STA);
		chk("curr", curr_dac, scc_pkg::ILIM_0);
		chk("or", q & 16'h00C0, 16'h0080);
		wr(CUR, 16'h03FF);
		wr(VOL, scc_pkg::VLIM_0);
		rd(2'd1, STA);
		chk("or", q & 16'h00C0, 16'h0040);
		wr(VOL, 16'h225E);
		rd(2'd1, STA);
		chk("or", q & 16'h00C0, 16'h0000);
		wr(MOD, 16'h0003);
		rd(2'd1, STA);
		chk("hold", q & 16'h0003, 16'h0001);
		chb("permit", charge_permit, 1'b0);
		wr(MOD, 16'h0009);
		cyc(1);
		chk("dac", curr_dac | volt_dac, 16'h0000);
		for (i = 0; i < 2; i++) begin
			@(posedge mclk);
			adapter_sense_input <= i[0];
			cyc(2);
			rd(2'd1, STA);
			chk("adapter", q & 16'h8001, i[0] ? 16'h8000 : 16'h0001);
		end
		wr(CUR, 16'h0100);
		wr(VOL, 16'h2000);
		@(posedge mclk);
		input_supply_pin <= 1'b0;
		cyc(3);
		rd(2'd1, STA);
		chk("supply", q & 16'h2000, 16'h2000);
		chb("permit", charge_permit, 1'b0);
		chk("dac", curr_dac ^ volt_dac, 16'h2100);
		@(posedge mclk);
		input_supply_pin <= 1'b1;
		wr(scc_pkg::CMD_BATTERY_ALARM_INPUT, 16'h0FFF);
		rd(2'd1, STA);
		chk("alarm", q & 16'h1000, 16'h0000);
		for (i = 12; i < 16; i++) begin
			wr(scc_pkg::CMD_BATTERY_ALARM_INPUT, 16'h0001 << i);
			cyc(2);
			chb("alert", alert_oe_n, 1'b0);
			chb("permit", charge_permit, 1'b0);
			rd(2'd2, 8'h00);
			chk("ara", q, 16'h0012);
			rd(2'd1, STA);
			chk("alarm", q & 16'h1000, 16'h1000);
			wr(CUR, 16'h0100);
			wr(VOL, 16'h2000);
			rd(2'd1, STA);
			chk("alarm", q & 16'h1000, 16'h0000);
		end
		wr(scc_pkg::CMD_BATTERY_ALARM_INPUT, 16'h1000);
		@(posedge mclk);
		adapter_sense_input <= 1'b0;
		cyc(2);
		rd(2'd1, STA);
		chk("alarm", q & 16'h1000, 16'h0000);
		@(posedge mclk);
		adapter_sense_input <= 1'b1;
		for (i = 0; i < 5; i++) begin
			@(posedge mclk);
			ilim_sel <= i[1:0];
			vlim_sel <= i[2:0];
			wr(CUR, 16'hFFFF);
			wr(VOL, 16'hFFFF);
			cyc(1);
			chk("vlim", volt_dac, vl[i]);
			chk("ilim", curr_dac, il[i[1:0]]);
		end
		wr(EXT, 16'h1000);
		rd(2'd1, EXT);
		chk("ext", q, {4'h1, VER});
		wr(MOD, 16'h0001);
		wr(MOD, 16'h0004);
		cyc(1);
		chk("restore", {pld, alert_oe_n, curr_dac[13:0]}, 16'h0000);
		rd(2'd1, STA);
		chk("restore", q & 16'h0001, 16'h0000);
		therm(20'd10000);
		therm(20'd10000);
		wr(CUR, 16'h0100);
		wr(VOL, 16'h2000);
		rd(2'd1, STA);
		therm(20'd100000);
		cyc(2);
		chb("alert", alert_oe_n, 1'b0);
		chk("dac", curr_dac | volt_dac, 16'h0000);
		therm(20'd10000);
		cyc(2);
		chb("alert", alert_oe_n, 1'b0);
		rd(2'd1, STA);
		chk("pack", q & 16'h4000, 16'h0000);
		foreach (oh[i]) begin
			therm(oh[i]);
			rd(2'd1, STA);
			chk("sense", q & 16'h0F00, sb[i]);
		end
		give_verdict();
	end
endmodule : tb

`default_nettype wire
